// ==== rtl/wdt_pkg.sv ====
// Shared constants for the indexed-port watchdog and its host controller.
// Assumes a single 100 MHz clock for both ends.
package wdt_pkg;
    // ==========================================================
    // I/O port selection and key bytes.
    localparam logic PORT_ADDR = 1'b0;
    localparam logic PORT_DATA = 1'b1;
    localparam logic [7:0] KEY_UNLOCK = 8'h87;
    localparam logic [7:0] KEY_LOCK = 8'hAA;
    // ==========================================================
    // Register indices and values.
    localparam logic [7:0] IDX_BANK_SELECT = 8'h07;
    localparam logic [7:0] IDX_FUNCTION_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_COUNT_UNIT_SELECT = 8'hF5;
    localparam logic [7:0] IDX_TIMEOUT_COUNT = 8'hF6;
    localparam logic [7:0] IDX_WATCHDOG_CONTROL_STATUS = 8'hF7;
    localparam logic [7:0] BANK_WATCHDOG = 8'h08;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] ACTIVATE_ON = 8'h01;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_UNIT_MIN = 3;
    localparam int BIT_STATUS = 4;
    localparam int BIT_FORCE = 5;
    localparam int BIT_KBD_EN = 6;
    // ==========================================================
    // Timing.
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int SEC_CYCLES = TICK_PERIOD_S * CLK_HZ;
    localparam int SECS_PER_MIN = 60;
    // ==========================================================
    // Host controller register map over AHB-Lite.
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0C;
    localparam logic [1:0] OP_ADDR_WRITE = 2'h0;
    localparam logic [1:0] OP_REG_WRITE = 2'h1;
    localparam logic [1:0] OP_REG_READ = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : wdt_pkg

// ==== rtl/io_port_if.sv ====
// Index/data I/O port link between host controller and watchdog device.
// Assumes both ends share mclk; strobes are one-cycle pulses.
`timescale 1ns/1ns
interface io_port_if;
    // Request from host: one-cycle write or read strobe.
    logic io_wr;
    logic io_rd;
    logic io_port_sel;
    logic [7:0] io_wdata;
    // Answer from device: one-cycle acknowledge, read data with it.
    logic io_ack;
    logic [7:0] io_rdata;
    modport dev (input io_wr, input io_rd, input io_port_sel, input io_wdata,
                 output io_ack, output io_rdata);
    modport host (output io_wr, output io_rd, output io_port_sel, output io_wdata,
                  input io_ack, input io_rdata);
endinterface : io_port_if

// ==== rtl/wdt_device.sv ====
// Watchdog timer reached through an index port and a data port.
// Assumes the host issues one strobe at a time and waits for io_ack.
// Contract
// - Index via address port, value via data port.
// - Two consecutive unlock keys open configuration.
// - Lock key closes configuration.
// - Bank value selects the watchdog registers.
// - Disabled at reset; activation write enables.
// - Unit bit three: seconds or minutes.
// - Count zero stops; 1 to 255 periods.
// - Lengths 1 to 255 seconds or minutes.
// - Count write restarts countdown from value.
// - Expiry asserts interrupt or reset output.
// - Jumper input routes expiry to reset/interrupt.
// - Interrupt low, held until timer restarted.
// - Control bit six lets keyboard restart.
// - Control bit five forces timeout, self-clears.
// - Control bit four reads timeout status.
`timescale 1ns/1ns
module wdt_device
    import wdt_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Host link.
    io_port_if.dev io,
    // Board inputs.
    input wire logic kbd_activity,
    input wire logic reset_or_irq_select_jumper,
    // Timeout outputs.
    output logic wdt_irq_n,
    output logic wdt_sys_reset
);
    localparam int DW = $clog2(SEC_CYC + 1);
    localparam logic [DW-1:0] SEC_LAST = DW'(SEC_CYC - 1);
    localparam logic [5:0] MIN_LAST = 6'(SECS_PER_MIN - 1);
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // ==========================================================
    // Port decode.
    logic unlocked_r;
    logic key_seen_r;
    logic [7:0] index_r;
    logic [7:0] bank_r;
    logic enable_r;
    logic unit_min_r;
    logic kbd_en_r;
    logic [7:0] count_r;
    logic [7:0] load_r;
    logic expired_r;
    logic [DW-1:0] sec_div_r;
    logic [5:0] min_div_r;
    logic addr_wr;
    logic data_wr;
    logic wd_bank;
    logic wr_count;
    logic wr_ctrl;
    logic sec_tick;
    logic unit_tick;
    logic kbd_restart;
    logic restart;
    logic force_evt;
    logic expire_evt;
    logic running;

    // Address-port writes carry keys or indices; data-port writes need unlock.
    assign addr_wr = io.io_wr && (io.io_port_sel == PORT_ADDR);
    assign data_wr = io.io_wr && (io.io_port_sel == PORT_DATA) && unlocked_r;
    assign wd_bank = (bank_r == BANK_WATCHDOG);
    assign wr_count = data_wr && wd_bank && (index_r == IDX_TIMEOUT_COUNT);
    assign wr_ctrl = data_wr && wd_bank && (index_r == IDX_WATCHDOG_CONTROL_STATUS);

    // Key sequence: any other address byte breaks a half-entered unlock.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unlocked_r <= 1'b0;
            key_seen_r <= 1'b0;
        end else if (addr_wr) begin
            if (!unlocked_r) begin
                key_seen_r <= (io.io_wdata == KEY_UNLOCK) && !key_seen_r;
                unlocked_r <= (io.io_wdata == KEY_UNLOCK) && key_seen_r;
            end else if (io.io_wdata == KEY_LOCK) begin
                unlocked_r <= 1'b0;
                key_seen_r <= 1'b0;
            end
        end
    end

    // Index register; only loaded while unlocked and never with the lock key, so the lock key and the locked-state unlock keys never become indices.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            index_r <= BYTE_ZERO;
        end else if (addr_wr && unlocked_r && (io.io_wdata != KEY_LOCK)) begin
            index_r <= io.io_wdata;
        end
    end

    // ==========================================================
    // Configuration registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bank_r <= BANK_RESET;
            enable_r <= 1'b0;
            unit_min_r <= 1'b0;
            kbd_en_r <= 1'b0;
        end else if (data_wr) begin
            if (index_r == IDX_BANK_SELECT) begin
                bank_r <= io.io_wdata;
            end
            if (wd_bank && (index_r == IDX_FUNCTION_ACTIVATE)) begin
                enable_r <= (io.io_wdata == ACTIVATE_ON);
            end
            if (wd_bank && (index_r == IDX_COUNT_UNIT_SELECT)) begin
                unit_min_r <= io.io_wdata[BIT_UNIT_MIN];
            end
            if (wr_ctrl) begin
                kbd_en_r <= io.io_wdata[BIT_KBD_EN];
            end
        end
    end

    // ==========================================================
    // Tick dividers. A restart realigns them so a fresh count gets full periods.
    assign sec_tick = (sec_div_r == SEC_LAST);
    assign unit_tick = sec_tick && (!unit_min_r || (min_div_r == MIN_LAST));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_div_r <= '0;
        end else if (restart || sec_tick) begin
            sec_div_r <= '0;
        end else begin
            sec_div_r <= sec_div_r + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            min_div_r <= '0;
        end else if (restart || unit_tick) begin
            min_div_r <= '0;
        end else if (sec_tick) begin
            min_div_r <= min_div_r + 1'b1;
        end
    end

    // ==========================================================
    // Countdown.
    assign kbd_restart = kbd_en_r && kbd_activity;
    assign restart = wr_count || kbd_restart;
    assign running = enable_r && (count_r != COUNT_RESET);
    assign force_evt = wr_ctrl && io.io_wdata[BIT_FORCE];
    assign expire_evt = (running && unit_tick && (count_r == COUNT_ONE) && !restart)
                        || force_evt;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= COUNT_RESET;
            load_r <= COUNT_RESET;
        end else if (wr_count) begin
            count_r <= io.io_wdata;
            load_r <= io.io_wdata;
        end else if (kbd_restart) begin
            count_r <= load_r;
        end else if (running && unit_tick) begin
            count_r <= count_r - 1'b1;
        end
    end

    // Timeout status is sticky; a forced timeout beats a same-cycle restart, and a restart cancels a same-cycle countdown expiry.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            expired_r <= 1'b0;
        end else if (expire_evt) begin
            expired_r <= 1'b1;
        end else if (restart) begin
            expired_r <= 1'b0;
        end
    end

    // ==========================================================
    // Timeout outputs, registered; jumper high routes to the interrupt line.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_irq_n <= 1'b1;
            wdt_sys_reset <= 1'b0;
        end else begin
            wdt_irq_n <= !(expired_r && reset_or_irq_select_jumper);
            wdt_sys_reset <= expired_r && !reset_or_irq_select_jumper;
        end
    end

    // ==========================================================
    // Answer: one-cycle ack for every strobe, read data beside it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            io.io_ack <= 1'b0;
            io.io_rdata <= BYTE_ZERO;
        end else begin
            io.io_ack <= io.io_wr || io.io_rd;
            io.io_rdata <= BYTE_ZERO;
            if (io.io_rd && (io.io_port_sel == PORT_DATA) && unlocked_r && wd_bank) begin
                case (index_r)
                    IDX_FUNCTION_ACTIVATE: io.io_rdata[BIT_ENABLE] <= enable_r;
                    IDX_COUNT_UNIT_SELECT: io.io_rdata[BIT_UNIT_MIN] <= unit_min_r;
                    IDX_TIMEOUT_COUNT: io.io_rdata <= count_r;
                    IDX_WATCHDOG_CONTROL_STATUS: begin
                        io.io_rdata[BIT_KBD_EN] <= kbd_en_r;
                        io.io_rdata[BIT_STATUS] <= expired_r;
                    end
                    default: io.io_rdata <= BYTE_ZERO;
                endcase
            end else if (io.io_rd && (io.io_port_sel == PORT_ADDR)) begin
                io.io_rdata <= index_r;
            end
        end
    end
endmodule : wdt_device

// ==== rtl/wdt_host.sv ====
// Host controller: AHB-Lite slave registers drive index/data port cycles.
// Assumes the device answers every strobe with a one-cycle io_ack.
`timescale 1ns/1ns
module wdt_host
    import wdt_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt.
    output logic irq,
    // Device link.
    io_port_if.host io
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_AWAIT = 3'b001, ST_DATA = 3'b010, ST_DWAIT = 3'b011
    } host_state_t;

    host_state_t state_r;
    logic [1:0] op_r;
    logic [7:0] idx_r;
    logic [7:0] dat_r;
    logic [7:0] rd_r;
    logic done_r;
    logic mask_r;
    logic wr_pend_r;
    logic [7:0] ofs_r;
    logic cmd_go;
    logic clr_done;
    logic done_evt;

    // ==========================================================
    // AHB address phase captured; write takes effect in its data phase.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            ofs_r <= BYTE_ZERO;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            ofs_r <= haddr[7:0];
        end
    end

    assign cmd_go = wr_pend_r && (ofs_r == OFS_CMD) && (state_r == ST_IDLE);
    assign clr_done = wr_pend_r && (ofs_r == OFS_INT_STAT) && hwdata[0];

    // Zero-wait slave: read data registered at the address-phase edge.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= WORD_ZERO;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= WORD_ZERO;
            if (hready && hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    OFS_STATUS: hrdata <= {16'h0000, rd_r, 7'h00, state_r != ST_IDLE};
                    OFS_INT_STAT: hrdata <= {31'h0000_0000, done_r};
                    OFS_INT_MASK: hrdata <= {31'h0000_0000, mask_r};
                    default: hrdata <= WORD_ZERO;
                endcase
            end
        end
    end

    // Mask register and sticky done flag; completion beats a same-cycle clear.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= 1'b0;
            done_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (wr_pend_r && (ofs_r == OFS_INT_MASK)) begin
                mask_r <= hwdata[0];
            end
            if (done_evt) begin
                done_r <= 1'b1;
            end else if (clr_done) begin
                done_r <= 1'b0;
            end
            irq <= done_r && mask_r;
        end
    end

    // ==========================================================
    // Port sequencer: index write on address port, then data port access.
    assign done_evt = io.io_ack && ((state_r == ST_DWAIT) ||
                      ((state_r == ST_AWAIT) && (op_r == OP_ADDR_WRITE)));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            op_r <= OP_ADDR_WRITE;
            idx_r <= BYTE_ZERO;
            dat_r <= BYTE_ZERO;
            rd_r <= BYTE_ZERO;
            io.io_wr <= 1'b0;
            io.io_rd <= 1'b0;
            io.io_port_sel <= PORT_ADDR;
            io.io_wdata <= BYTE_ZERO;
        end else begin
            io.io_wr <= 1'b0;
            io.io_rd <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        op_r <= hwdata[17:16];
                        idx_r <= hwdata[15:8];
                        dat_r <= hwdata[7:0];
                        io.io_wr <= 1'b1;
                        io.io_port_sel <= PORT_ADDR;
                        io.io_wdata <= (hwdata[17:16] == OP_ADDR_WRITE) ?
                                       hwdata[7:0] : hwdata[15:8];
                        state_r <= ST_AWAIT;
                    end
                end
                ST_AWAIT: begin
                    if (io.io_ack) begin
                        state_r <= (op_r == OP_ADDR_WRITE) ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    io.io_port_sel <= PORT_DATA;
                    io.io_wdata <= dat_r;
                    io.io_wr <= (op_r == OP_REG_WRITE);
                    io.io_rd <= (op_r != OP_REG_WRITE);
                    state_r <= ST_DWAIT;
                end
                ST_DWAIT: begin
                    if (io.io_ack) begin
                        rd_r <= (op_r == OP_REG_READ) ? io.io_rdata : rd_r;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule : wdt_host

// ==== test/wdt_link_checker.sv ====
// Concurrent checks on the index/data link and the timeout pins.
// Assumes it is instantiated beside the link interface in the bench top.
`timescale 1ns/1ns
module wdt_link_checker (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Link signals.
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_ack,
    input wire logic [7:0] io_rdata,
    // Board inputs and timeout outputs.
    input wire logic kbd_activity,
    input wire logic reset_or_irq_select_jumper,
    input wire logic wdt_irq_n,
    input wire logic wdt_sys_reset
);
    // ==========================================================
    // Handshake steps.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence strobe_s;
        io_wr || io_rd;
    endsequence
    sequence ack_s;
        io_ack ##1 !io_ack;
    endsequence
    // ==========================================================
    // Link behaviour.
    ack_timing_a: assert property (strobe_s |=> ack_s)
        else $error("Strobe not answered by a one-cycle ack.");
    stray_ack_a: assert property (io_ack |-> $past(io_wr || io_rd))
        else $error("Ack without a strobe.");
    rdata_idle_a: assert property (!io_ack |-> io_rdata == 8'h00)
        else $error("Read byte not zero outside ack.");
    single_strobe_a: assert property (!(io_wr && io_rd))
        else $error("Write and read strobes together.");
    strobe_pulse_a: assert property (io_wr |=> !io_wr)
        else $error("Write strobe longer than one cycle.");
    // ==========================================================
    // Timeout routing and holding.
    route_irq_a: assert property (!reset_or_irq_select_jumper |=> wdt_irq_n)
        else $error("Interrupt driven while reset route selected.");
    route_reset_a: assert property (reset_or_irq_select_jumper |=> !wdt_sys_reset)
        else $error("Reset driven while interrupt route selected.");
    // A restart reaches the pin two cycles after its strobe, so both cycles are excused.
    irq_held_a: assert property ((!wdt_irq_n && reset_or_irq_select_jumper && !io_wr
        && !$past(io_wr) && !kbd_activity && !$past(kbd_activity)) |=> !wdt_irq_n)
        else $error("Interrupt released without a restart.");
endmodule : wdt_link_checker

// ==== test/indexed_port_watchdog_timer_tb_top.sv ====
// Bench joining the host controller and the watchdog device over the link.
// Assumes a shortened second of TICK cycles; software speaks AHB-Lite only.
`timescale 1ns/1ns
module indexed_port_watchdog_timer_tb_top
    import wdt_pkg::*;
;
    // ==========================================================
    // Signals.
    localparam int TICK = 20;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = WORD_ZERO;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    logic kbd_activity = 1'b0;
    logic reset_or_irq_select_jumper = 1'b1;
    logic wdt_irq_n;
    logic wdt_sys_reset;
    int cyc = 0;
    int t0 = 0;
    int tk;
    int miscompares = 0;
    int comparisons = 0;
    logic [7:0] q;
    logic [31:0] w;
    // The single slave's ready is the bus ready.
    assign hready = hreadyout;
    io_port_if io_port_if_inst ();
    wdt_host wdt_host_inst (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .io(io_port_if_inst.host));
    wdt_device #(.SEC_CYC(TICK)) wdt_device_inst (.mclk(mclk), .reset_n(reset_n),
        .io(io_port_if_inst.dev), .kbd_activity(kbd_activity),
        .reset_or_irq_select_jumper(reset_or_irq_select_jumper),
        .wdt_irq_n(wdt_irq_n), .wdt_sys_reset(wdt_sys_reset));
    wdt_link_checker wdt_link_checker_inst (.mclk(mclk), .reset_n(reset_n),
        .io_wr(io_port_if_inst.io_wr), .io_rd(io_port_if_inst.io_rd),
        .io_ack(io_port_if_inst.io_ack), .io_rdata(io_port_if_inst.io_rdata),
        .kbd_activity(kbd_activity), .reset_or_irq_select_jumper(reset_or_irq_select_jumper),
        .wdt_irq_n(wdt_irq_n), .wdt_sys_reset(wdt_sys_reset));
    // ==========================================================
    // Clock, cycle count with hang limit, and time of the last data-port write.
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            end_sim();
        end
    end
    always @(posedge mclk) begin
        if (io_port_if_inst.io_wr === 1'b1 && io_port_if_inst.io_port_sel === 1'b1) begin
            t0 <= cyc;
        end
    end
    // ==========================================================
    // Tasks.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One single AHB transfer; the answer is awaited, never assumed.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        r = hrdata;
    endtask : ahb
    // Issue one link command and poll until the controller is idle.
    task automatic cmd(input logic [1:0] op, input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] s;
        ahb(1'b1, OFS_CMD, {14'h0000, op, idx, v}, s);
        s = 32'h0000_0001;
        while (s[0] !== 1'b0) ahb(1'b0, OFS_STATUS, WORD_ZERO, s);
        q = s[15:8];
    endtask : cmd
    task automatic wait_exp(input int n, input int base);
        int start;
        start = cyc;
        while (wdt_irq_n !== 1'b0 && wdt_sys_reset !== 1'b1 && cyc - start < 20000)
            @(posedge mclk);
        check("expiry_time", 32'(cyc - base >= n * TICK && cyc - base <= n * TICK + 5), 1);
    endtask : wait_exp
    task automatic kbd_pulse();
        tk = cyc;
        kbd_activity <= 1'b1;
        @(posedge mclk);
        kbd_activity <= 1'b0;
    endtask : kbd_pulse
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check("irq_n", wdt_irq_n, 1);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, KEY_UNLOCK);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, 8'h01);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, KEY_UNLOCK);
        cmd(OP_REG_WRITE, IDX_BANK_SELECT, BANK_WATCHDOG);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h05);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, KEY_UNLOCK);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, KEY_UNLOCK);
        cmd(OP_REG_WRITE, IDX_BANK_SELECT, BANK_WATCHDOG);
        cmd(OP_REG_READ, IDX_TIMEOUT_COUNT, BYTE_ZERO);
        check("count_default", q, 8'h00);
        cmd(OP_REG_READ, IDX_COUNT_UNIT_SELECT, BYTE_ZERO);
        check("unit_default", q & 8'h08, 8'h00);
        cmd(OP_REG_READ, IDX_WATCHDOG_CONTROL_STATUS, BYTE_ZERO);
        check("ctrl_default", q & 8'h70, 8'h00);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h03);
        repeat (5 * TICK) @(posedge mclk);
        check("disabled", wdt_irq_n, 1);
        cmd(OP_REG_WRITE, IDX_FUNCTION_ACTIVATE, ACTIVATE_ON);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h02);
        wait_exp(2, t0);
        check("reset_out", wdt_sys_reset, 0);
        cmd(OP_REG_READ, IDX_WATCHDOG_CONTROL_STATUS, BYTE_ZERO);
        check("status", q & 8'h10, 8'h10);
        check("irq_held", wdt_irq_n, 0);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'hFF);
        check("irq_release", wdt_irq_n, 1);
        cmd(OP_REG_READ, IDX_TIMEOUT_COUNT, BYTE_ZERO);
        check("count_max", q, 8'hFF);
        wait_exp(255, t0);
        reset_or_irq_select_jumper <= 1'b0;
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h01);
        wait_exp(1, t0);
        check("irq_unused", wdt_irq_n, 1);
        reset_or_irq_select_jumper <= 1'b1;
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, COUNT_RESET);
        repeat (3 * TICK) @(posedge mclk);
        check("stopped", wdt_irq_n, 1);
        cmd(OP_REG_WRITE, IDX_COUNT_UNIT_SELECT, 8'h08);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h01);
        wait_exp(60, t0);
        cmd(OP_REG_WRITE, IDX_COUNT_UNIT_SELECT, BYTE_ZERO);
        cmd(OP_REG_WRITE, IDX_WATCHDOG_CONTROL_STATUS, 8'h40);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h02);
        repeat (20) @(posedge mclk);
        kbd_pulse();
        wait_exp(2, tk);
        cmd(OP_REG_WRITE, IDX_WATCHDOG_CONTROL_STATUS, BYTE_ZERO);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'h02);
        repeat (20) @(posedge mclk);
        kbd_pulse();
        wait_exp(2, t0);
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, COUNT_RESET);
        cmd(OP_REG_WRITE, IDX_WATCHDOG_CONTROL_STATUS, 8'h20);
        check("forced", wdt_irq_n, 0);
        cmd(OP_REG_READ, IDX_WATCHDOG_CONTROL_STATUS, BYTE_ZERO);
        check("force_clear", q & 8'h30, 8'h10);
        // A nonzero count makes the locked read below able to tell lock from content.
        cmd(OP_REG_WRITE, IDX_TIMEOUT_COUNT, 8'hFF);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, KEY_LOCK);
        cmd(OP_REG_READ, IDX_TIMEOUT_COUNT, BYTE_ZERO);
        check("locked_read", q, 8'h00);
        // Controller interrupt: unmask, clear by writing one, masked done.
        ahb(1'b1, OFS_INT_MASK, 32'h0000_0001, w);
        repeat (2) @(posedge mclk);
        check("irq_on", irq, 1);
        ahb(1'b1, OFS_INT_STAT, 32'h0000_0001, w);
        repeat (2) @(posedge mclk);
        check("irq_clear", irq, 0);
        ahb(1'b1, OFS_INT_MASK, WORD_ZERO, w);
        cmd(OP_ADDR_WRITE, BYTE_ZERO, BYTE_ZERO);
        ahb(1'b0, OFS_INT_STAT, WORD_ZERO, w);
        check("done_sticky", w, 32'h0000_0001);
        check("irq_masked", irq, 0);
        ahb(1'b0, 8'h10, WORD_ZERO, w);
        check("unmapped", w, WORD_ZERO);
        check("hresp", hresp, 0);
        end_sim();
    end
endmodule : indexed_port_watchdog_timer_tb_top
